// ---- logic/pcm_clock_gen.sv ----
// master clock generator with axi4-lite registers
// assumes single clock domain; clock outputs are enables at clk rate
//
// Overview of operation
// - reset selects slow clock for master clock
// - one write enables oscillator, loads count
// - stable flag sets after startup count
// - pll output equals input div times mul+1
// - pll fields: div low, count 8, mul 16
// - pll write counts startup then sets lock
// - master clock write clears ready, sets it again later
// - peripheral clock enable by id write
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pcm_clock_gen (
  input  wire logic        clk,       // system clock 125 MHz
  input  wire logic        nrst,      // async reset, active low
  input  wire logic        ce,        // clock enable, freezes state
  input  wire logic [7:0]  awaddr,    // write address
  input  wire logic        awvalid,   // write address valid
  output logic             awready,   // write address ready
  input  wire logic [31:0] wdata,     // write data
  input  wire logic [3:0]  wstrb,     // write strobes
  input  wire logic        wvalid,    // write data valid
  output logic             wready,    // write data ready
  output logic [1:0]       bresp,     // write response
  output logic             bvalid,    // write response valid
  input  wire logic        bready,    // write response ready
  input  wire logic [7:0]  araddr,    // read address
  input  wire logic        arvalid,   // read address valid
  output logic             arready,   // read address ready
  output logic [31:0]      rdata,     // read data
  output logic [1:0]       rresp,     // read response
  output logic             rvalid,    // read data valid
  input  wire logic        rready,    // read data ready
  output logic [1:0]       mck_src,   // master clock source in effect
  output logic [2:0]       mck_master_clock_prescaler,  // prescaler in effect
  output logic [31:0]      periph_clk_en, // peripheral clock enables
  output logic             irq        // interrupt, level, active high
);
  // register state
  logic [31:0]             main_osc_config;
  pcm_pkg::pcm_pll_s       pll_config;
  logic [31:0]             master_clock_config;
  logic [2:0]              status;
  logic [2:0]              irq_stat;
  logic [2:0]              irq_mask;
  logic [1:0]              pend_src;
  logic [2:0]              pend_master_clock_prescaler;
  logic [15:0]             slow_cnt;
  logic                    slow_tick;
  logic [7:0]              aw_addr_q;
  logic [31:0]             w_data_q;
  logic [3:0]              w_strb_q;
  logic                    aw_held;
  logic                    w_held;

  // write channel capture, either order
  wire aw_take   = awvalid && awready;
  wire w_take    = wvalid && wready;
  wire [7:0]  wa = aw_held ? aw_addr_q : awaddr;
  wire [31:0] wd = w_held ? w_data_q : wdata;
  wire [3:0]  ws = w_held ? w_strb_q : wstrb;
  wire have_aw   = aw_held || aw_take;
  wire have_w    = w_held || w_take;
  wire wr_go     = ce && have_aw && have_w && !bvalid;
  wire full_word = (ws == 4'hf);
  wire wr_osc    = wr_go && full_word && wa == pcm_pkg::MAIN_OSC_CONFIG_OFS;
  wire wr_pll    = wr_go && full_word && wa == pcm_pkg::PLL_CONFIG_OFS;
  wire wr_mck    = wr_go && full_word &&
                   wa == pcm_pkg::MASTER_CLOCK_CFG_OFS;
  wire wr_stat   = wr_go && full_word && wa == pcm_pkg::STATUS_OFS;
  wire wr_mask   = wr_go && full_word && wa == pcm_pkg::IRQ_MASK_OFS;
  wire wr_peripheral_clock_enable_reg   = wr_go && full_word &&
                   wa == pcm_pkg::PERIPH_CLK_ENABLE_OFS;
  wire wr_known  = wa == pcm_pkg::MAIN_OSC_CONFIG_OFS ||
                   wa == pcm_pkg::PLL_CONFIG_OFS ||
                   wa == pcm_pkg::MASTER_CLOCK_CFG_OFS ||
                   wa == pcm_pkg::STATUS_OFS ||
                   wa == pcm_pkg::IRQ_MASK_OFS ||
                   wa == pcm_pkg::PERIPH_CLK_ENABLE_OFS;

  // slow clock tick from a divider of the system clock
  wire slow_wrap = slow_cnt == 16'(pcm_pkg::SLOW_DIV - 1);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slow_cnt  <= 16'h0000;
      slow_tick <= 1'b0;
    end else if (ce) begin
      slow_cnt  <= slow_wrap ? 16'h0000 : slow_cnt + 16'h0001;
      slow_tick <= slow_wrap;
    end
  end

  // oscillator startup: eight slow ticks per count unit
  wire [7:0]  osc_count_f = wd[pcm_pkg::OSC_COUNT_LSB +: 8];
  wire        osc_en_f    = wd[pcm_pkg::OSC_ENABLE_BIT];
  wire [13:0] osc_load    = {3'h0, osc_count_f, 3'h0} + 14'h0001;
  wire        osc_done;
  pcm_slow_timer u_osc_timer (
    .clk   (clk),
    .nrst  (nrst),
    .ce    (ce),
    .tick  (slow_tick),
    .start (wr_osc && osc_en_f),
    .stop  (wr_osc && !osc_en_f),
    .load  (osc_load),
    .done  (osc_done)
  );

  // pll lock counter in slow ticks, count starts at bit 8
  wire [5:0]  pll_count_f = wd[pcm_pkg::PLL_COUNT_LSB +: 6];
  wire [13:0] pll_load    = {8'h00, pll_count_f} + 14'h0001;
  logic [13:0] pll_cnt;
  logic        pll_run;
  wire pll_done = pll_run && slow_tick && pll_cnt <= 14'h0001;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pll_cnt <= 14'h0000;
      pll_run <= 1'b0;
    end else if (ce) begin
      if (wr_pll) begin
        pll_cnt <= pll_load;
        pll_run <= 1'b1;
      end else if (pll_done) begin
        pll_run <= 1'b0;
      end else if (pll_run && slow_tick) begin
        pll_cnt <= pll_cnt - 14'h0001;
      end
    end
  end

  // master clock switch: takes effect after a short slow-clock wait
  logic [1:0] sw_cnt;
  logic       sw_run;
  wire sw_done = sw_run && slow_tick &&
                 sw_cnt == 2'(pcm_pkg::SWITCH_SLOW - 1);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_cnt <= 2'h0;
      sw_run <= 1'b0;
    end else if (ce) begin
      if (wr_mck) begin
        sw_cnt <= 2'h0;
        sw_run <= 1'b1;
      end else if (sw_done) begin
        sw_run <= 1'b0;
      end else if (sw_run && slow_tick) begin
        sw_cnt <= sw_cnt + 2'h1;
      end
    end
  end

  // configuration registers and the clock selection in effect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      main_osc_config     <= 32'h0000_0000;
      pll_config          <= '0;
      master_clock_config <= 32'h0000_0000;
      pend_src            <= 2'h0;
      pend_master_clock_prescaler           <= 3'h0;
      mck_src             <= pcm_pkg::PCM_SRC_SLOW;
      mck_master_clock_prescaler            <= 3'h0;
      irq_mask            <= 3'h0;
      periph_clk_en       <= pcm_pkg::PERIPH_CLK_RESET;
    end else if (ce) begin
      if (wr_osc)
        main_osc_config <= wd & 32'h0000_ff01;
      if (wr_pll) begin
        pll_config.div   <= wd[pcm_pkg::PLL_DIV_LSB +: 8];
        pll_config.count <= pll_count_f;
        pll_config.mul   <= wd[pcm_pkg::PLL_MUL_LSB +: 11];
      end
      if (wr_mck) begin
        master_clock_config <= wd & 32'h0000_001f;
        pend_src  <= wd[pcm_pkg::MCK_SRC_LSB +: 2];
        pend_master_clock_prescaler <= wd[pcm_pkg::MCK_MASTER_CLOCK_PRESCALER_LSB +: 3];
      end
      if (sw_done) begin
        mck_src  <= pend_src;
        mck_master_clock_prescaler <= pend_master_clock_prescaler;
      end
      if (wr_mask)
        irq_mask <= wd[2:0];
      if (wr_peripheral_clock_enable_reg)
        periph_clk_en <= periph_clk_en | wd;
    end
  end

  // status flags: oscillator stable, pll locked, master ready
  wire osc_off = wr_osc && !osc_en_f;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status <= pcm_pkg::STATUS_RESET;
    end else if (ce) begin
      if (osc_done)
        status[pcm_pkg::STAT_OSC_BIT] <= 1'b1;
      else if (wr_osc)
        status[pcm_pkg::STAT_OSC_BIT] <= 1'b0;
      if (pll_done)
        status[pcm_pkg::STAT_LOCK_BIT] <= 1'b1;
      else if (wr_pll || osc_off)
        status[pcm_pkg::STAT_LOCK_BIT] <= 1'b0;
      if (wr_mck)
        status[pcm_pkg::STAT_MASTER_CLOCK_READY_FLAG_BIT] <= 1'b0;
      else if (sw_done)
        status[pcm_pkg::STAT_MASTER_CLOCK_READY_FLAG_BIT] <= 1'b1;
    end
  end

  // sticky interrupt bits, set wins over write-one-to-clear
  wire [2:0] irq_set = {sw_done, pll_done, osc_done};
  wire [2:0] irq_clr = wr_stat ? wd[2:0] : 3'h0;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= 3'h0;
      irq      <= 1'b0;
    end else if (ce) begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq      <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // axi write channel handshake and response
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= 2'h0;
    end else if (ce) begin
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        awready <= 1'b0;
        wready  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (wr_known && full_word) ? 2'h0 : 2'h2;
      end else begin
        if (aw_take) begin
          aw_held   <= 1'b1;
          aw_addr_q <= awaddr;
          awready   <= 1'b0;
        end
        if (w_take) begin
          w_held   <= 1'b1;
          w_data_q <= wdata;
          w_strb_q <= wstrb;
          wready   <= 1'b0;
        end
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // read decode
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (araddr)
      pcm_pkg::MAIN_OSC_CONFIG_OFS:   rd_val = main_osc_config;
      pcm_pkg::PLL_CONFIG_OFS:        rd_val = {5'h00, pll_config.mul,
                                                2'h0, pll_config.count,
                                                pll_config.div};
      pcm_pkg::MASTER_CLOCK_CFG_OFS:  rd_val = master_clock_config;
      pcm_pkg::STATUS_OFS:            rd_val = {26'h0, irq_stat, status};
      pcm_pkg::IRQ_MASK_OFS:          rd_val = {29'h0, irq_mask};
      pcm_pkg::PERIPH_CLK_STATUS_OFS: rd_val = periph_clk_en;
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  // axi read channel, one cycle answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= 2'h0;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_val;
        rresp   <= rd_ok ? 2'h0 : 2'h2;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // checks on the clock control behaviour
  reset_source_a: assert property (@(posedge clk)
    $rose(nrst) |-> mck_src == 2'h0)
    else $error("master clock not on slow clock after reset");
  osc_stable_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && osc_done |=> status[0])
    else $error("oscillator stable flag not set");
  osc_start_a: assert property (
    @(posedge clk) disable iff (!nrst)
    wr_osc && osc_en_f && ce |=> !status[0] ##1 !status[0])
    else $error("stable flag set too early");
  osc_load_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && wr_osc |=> main_osc_config[15:8] == $past(osc_count_f))
    else $error("oscillator count not loaded from bit 8");
  pll_lock_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && wr_pll |=> !status[1])
    else $error("pll lock not cleared on config write");
  pll_lock_set_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && pll_done |=> status[1])
    else $error("pll lock flag not set after count");
  pll_fields_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && wr_pll |=> pll_config.mul == $past(wd[26:16]))
    else $error("pll multiply field misplaced");
  mck_clear_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && wr_mck |=> !status[2])
    else $error("master ready not cleared by write");
  mck_apply_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && sw_done |=> status[2] && mck_src == $past(pend_src))
    else $error("master clock switch not applied");
  periph_sys_a: assert property (
    @(posedge clk) disable iff (!nrst)
    periph_clk_en[1])
    else $error("system controller clock dropped");
  periph_on_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && wr_peripheral_clock_enable_reg |=> (periph_clk_en & $past(wd)) == $past(wd))
    else $error("peripheral clock not switched on");
endmodule : pcm_clock_gen

// ---- logic/pcm_pkg.sv ----
// package for the power clock manager clock generator
// assumes one 125 MHz system clock and an AXI4-Lite register bus
package pcm_pkg;
  // register byte offsets
  localparam logic [7:0] MAIN_OSC_CONFIG_OFS   = 8'h00;
  localparam logic [7:0] PLL_CONFIG_OFS        = 8'h04;
  localparam logic [7:0] MASTER_CLOCK_CFG_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS            = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFS          = 8'h10;
  localparam logic [7:0] PERIPH_CLK_ENABLE_OFS = 8'h14;
  localparam logic [7:0] PERIPH_CLK_STATUS_OFS = 8'h18;
  // field positions
  localparam int OSC_ENABLE_BIT   = 0;
  localparam int OSC_COUNT_LSB    = 8;
  localparam int PLL_DIV_LSB      = 0;
  localparam int PLL_COUNT_LSB    = 8;
  localparam int PLL_MUL_LSB      = 16;
  localparam int MCK_SRC_LSB      = 0;
  localparam int MCK_MASTER_CLOCK_PRESCALER_LSB     = 2;
  localparam int STAT_OSC_BIT     = 0;
  localparam int STAT_LOCK_BIT    = 1;
  localparam int STAT_MASTER_CLOCK_READY_FLAG_BIT  = 2;
  // reset values
  localparam logic [31:0] PERIPH_CLK_RESET = 32'h0000_0002;
  localparam logic [2:0]  STATUS_RESET     = 3'h4;
  // slow clock: 32 kHz derived from the 125 MHz system clock
  localparam int SLOW_CLK_KHZ  = 32;
  localparam int SYS_CLK_MHZ   = 125;
  localparam int SLOW_DIV      = (SYS_CLK_MHZ * 1000) / SLOW_CLK_KHZ;
  localparam int SLOW_PER_UNIT = 8;
  localparam int SWITCH_SLOW   = 2;
  // clock sources
  typedef enum logic [1:0] {
    PCM_SRC_SLOW = 2'b00,
    PCM_SRC_MAIN = 2'b01,
    PCM_SRC_RSVD = 2'b10,
    PCM_SRC_PLL  = 2'b11
  } pcm_src_e;
  // pll settings carried together
  typedef struct packed {
    logic [10:0] mul;
    logic [5:0]  count;
    logic [7:0]  div;
  } pcm_pll_s;
endpackage : pcm_pkg

// ---- logic/pcm_slow_timer.sv ----
// startup counter timed in slow clock ticks
// assumes tick is a one-cycle pulse at the slow clock rate
`timescale 1ns/1ps
module pcm_slow_timer (
  input  wire logic        clk,    // system clock
  input  wire logic        nrst,   // async reset, active low
  input  wire logic        ce,     // clock enable
  input  wire logic        tick,   // slow clock tick
  input  wire logic        start,  // load and run
  input  wire logic        stop,   // abandon the count
  input  wire logic [13:0] load,   // ticks to wait
  output logic             done    // pulse when count elapses
);
  logic [13:0] cnt;
  logic        run;
  wire         last = run && tick && (cnt <= 14'h0001);
  // count down in slow ticks, done pulses on expiry
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt  <= 14'h0000;
      run  <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        cnt <= load;
        run <= 1'b1;
      end else if (stop) begin
        run <= 1'b0;
      end else if (last) begin
        run  <= 1'b0;
        done <= 1'b1;
      end else if (run && tick) begin
        cnt <= cnt - 14'h0001;
      end
    end
  end
endmodule : pcm_slow_timer

// ---- bench/pcm_axi_master.sv ----
// axi4-lite master standing in for the controlling software
// assumes one clock; signals move by nba right after a rising edge
`timescale 1ns/1ps
module pcm_axi_master (
  input  wire logic        clk,     // system clock
  output logic [7:0]       awaddr,  // write address
  output logic             awvalid, // write address valid
  input  wire logic        awready, // write address ready
  output logic [31:0]      wdata,   // write data
  output logic [3:0]       wstrb,   // write strobes
  output logic             wvalid,  // write data valid
  input  wire logic        wready,  // write data ready
  input  wire logic        bvalid,  // write response valid
  output logic             bready,  // write response ready
  output logic [7:0]       araddr,  // read address
  output logic             arvalid, // read address valid
  input  wire logic        arready, // read address ready
  input  wire logic [31:0] rdata,   // read data
  input  wire logic        rvalid,  // read data valid
  output logic             rready   // read data ready
);
  // idle bus from time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, wdata, wstrb, araddr} = '0;
  end

  // one write; released payload shows its inverse, not a stale value
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    logic aw_ok, w_ok, b_ok;
    {aw_ok, w_ok, b_ok} = 3'h0;
    @(posedge clk);
    {awaddr, wdata, wstrb} <= {a, v, s};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!b_ok) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        {awvalid, awaddr} <= {1'b0, ~a};
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        {wvalid, wdata} <= {1'b0, ~v};
      end
      if (bvalid === 1'b1) begin
        b_ok = 1'b1;
        bready <= 1'b0;
      end
    end
  endtask : wr

  // one read; data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic ar_ok, r_ok;
    {ar_ok, r_ok} = 2'h0;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!r_ok) begin
      @(posedge clk);
      if (!ar_ok && arready === 1'b1) begin
        ar_ok = 1'b1;
        {arvalid, araddr} <= {1'b0, ~a};
      end
      if (rvalid === 1'b1) begin
        r_ok = 1'b1;
        v = rdata;
        rready <= 1'b0;
      end
    end
  endtask : rd
endmodule : pcm_axi_master

// ---- bench/tb_top.sv ----
// self-checking bench for the clock generator register block
// assumes the partner master and the design's package are compiled first
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [1:0]  resp;
    logic [31:0] data;
    logic [31:0] mask;
  } pcm_exp_s;
  localparam int LIMIT = 80000;
  localparam int TICK  = pcm_pkg::SLOW_DIV;
  logic        clk, nrst, ce, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, periph_clk_en, d, id_bit, pll_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, mck_src;
  logic [2:0]  mck_master_clock_prescaler;
  pcm_exp_s    rq[$];
  logic [1:0]  bq[$];
  int          errors, num_checks, cycles, t0;

  // clock at 125 MHz
  initial clk = 1'b0;
  always #4 clk = ~clk;

  pcm_clock_gen pcm_clock_gen_i (.clk(clk), .nrst(nrst), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .mck_src(mck_src),
    .mck_master_clock_prescaler(mck_master_clock_prescaler), .periph_clk_en(periph_clk_en), .irq(irq));

  pcm_axi_master pcm_axi_master_i (.clk(clk), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rvalid(rvalid), .rready(rready));

  task automatic print_verdict();
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // drivers note the expected answer, then run the bus cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s = 4'hf, input logic [1:0] r = 2'h0);
    bq.push_back(r);
    pcm_axi_master_i.wr(a, v, s);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic [1:0] r = 2'h0);
    rq.push_back({r, e, m});
    pcm_axi_master_i.rd(a, d);
  endtask : rd

  // poll a status bit, then check the time since t0 lies in [lo, hi]
  task automatic poll(input int b, input int lo, input int hi,
                      input string n);
    d = '0;
    for (int i = 0; i < 40000 && d[b] !== 1'b1; i++)
      rd(pcm_pkg::STATUS_OFS, 32'h0, 32'h0);
    chk(n, 32'h1, {31'h0, (cycles - t0) >= lo && (cycles - t0) <= hi});
  endtask : poll

  // settled port check away from the launching edge
  task automatic pchk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
    @(negedge clk);
    chk(n, e, g);
  endtask : pchk

  // monitor: oldest note is compared with each response seen
  always @(posedge clk) begin : mon
    pcm_exp_s e;
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = rq.pop_front();
      chk("rresp", {30'h0, e.resp}, {30'h0, rresp});
      chk("rdata", e.data & e.mask, rdata & e.mask);
    end
    if (bvalid === 1'b1 && bready === 1'b1)
      chk("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
  end

  // cycle count and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      print_verdict();
    end
  end

  // main sequence
  initial begin
    {nrst, ce, errors, num_checks, cycles} = {2'b01, 32'h0, 32'h0, 32'h0};
    void'($urandom(32'h926833c0));
    pll_v = {5'h0, 11'd72, 2'h0, 6'd1, 8'd14};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    pchk("mck_src", 32'h0, {30'h0, mck_src});
    pchk("periph_en", pcm_pkg::PERIPH_CLK_RESET, periph_clk_en);
    rd(pcm_pkg::STATUS_OFS, 32'h4, '1);
    rd(pcm_pkg::MASTER_CLOCK_CFG_OFS, 32'h0, '1);
    // refused accesses leave state alone
    wr(8'h1c, 32'h1, 4'hf, 2'h2);
    rd(8'h1c, 32'h0, '1, 2'h2);
    wr(pcm_pkg::MAIN_OSC_CONFIG_OFS, 32'h101, 4'h3, 2'h2);
    rd(pcm_pkg::MAIN_OSC_CONFIG_OFS, 32'h0, '1);
    // oscillator start with count 1, only its event unmasked
    wr(pcm_pkg::IRQ_MASK_OFS, 32'h1);
    t0 = cycles;
    wr(pcm_pkg::MAIN_OSC_CONFIG_OFS, 32'h101);
    rd(pcm_pkg::STATUS_OFS, 32'h0, 32'h1);
    poll(pcm_pkg::STAT_OSC_BIT, 8 * TICK, 10 * TICK,
         "osc_time");
    pchk("irq_osc", 32'h1, {31'h0, irq});
    wr(pcm_pkg::STATUS_OFS, 32'h1);
    rd(pcm_pkg::STATUS_OFS, 32'h1, 32'h9);
    pchk("irq_clr", 32'h0, {31'h0, irq});
    // pll set up only once the oscillator is stable
    t0 = cycles;
    wr(pcm_pkg::PLL_CONFIG_OFS, pll_v);
    rd(pcm_pkg::STATUS_OFS, 32'h0, 32'h2);
    rd(pcm_pkg::PLL_CONFIG_OFS, pll_v, '1);
    poll(pcm_pkg::STAT_LOCK_BIT, TICK, 3 * TICK, "lock_time");
    pchk("irq_masked", 32'h0, {31'h0, irq});
    wr(pcm_pkg::IRQ_MASK_OFS, 32'h3);
    rd(pcm_pkg::IRQ_MASK_OFS, 32'h3, 32'h7);
    pchk("irq_lock", 32'h1, {31'h0, irq});
    wr(pcm_pkg::STATUS_OFS, 32'h2);
    rd(pcm_pkg::STATUS_OFS, 32'h2, 32'h12);
    pchk("irq_clr2", 32'h0, {31'h0, irq});
    // prescaler first, then the pll as source
    t0 = cycles;
    wr(pcm_pkg::MASTER_CLOCK_CFG_OFS, 32'h4);
    rd(pcm_pkg::STATUS_OFS, 32'h0, 32'h4);
    poll(pcm_pkg::STAT_MASTER_CLOCK_READY_FLAG_BIT, TICK, 3 * TICK, "master_clock_prescaler_time");
    pchk("mck_master_clock_prescaler", 32'h1, {29'h0, mck_master_clock_prescaler});
    pchk("mck_src0", 32'h0, {30'h0, mck_src});
    t0 = cycles;
    wr(pcm_pkg::MASTER_CLOCK_CFG_OFS, 32'h7);
    rd(pcm_pkg::STATUS_OFS, 32'h0, 32'h4);
    poll(pcm_pkg::STAT_MASTER_CLOCK_READY_FLAG_BIT, TICK, 3 * TICK, "src_time");
    pchk("mck_src3", 32'h3, {30'h0, mck_src});
    rd(pcm_pkg::STATUS_OFS, 32'h27, 32'h3f);
    // random peripheral clock switched on by its id
    id_bit = 32'h1 << (2 + $urandom % 30);
    wr(pcm_pkg::PERIPH_CLK_ENABLE_OFS, id_bit);
    rd(pcm_pkg::PERIPH_CLK_STATUS_OFS, id_bit | 32'h2, '1);
    pchk("periph_on", id_bit | 32'h2, periph_clk_en);
    // reset in mid-run falls back to the slow clock
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    pchk("mck_src_rst", 32'h0, {30'h0, mck_src});
    pchk("periph_rst", pcm_pkg::PERIPH_CLK_RESET, periph_clk_en);
    rd(pcm_pkg::STATUS_OFS, 32'h4, '1);
    @(posedge clk);
    print_verdict();
  end
endmodule : tb_top
